// *** csc_channel_status.sv ***
// Channel status and control pin logic with an APB register port.
// Assumes pins arrive asynchronous; analog level, checker and clock
// sources come from logic on sys_clk.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
module csc_channel_status
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [CSC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSC_DW-1:0] pwdata,
  output logic [CSC_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_swing_mvpp,
  output csc_pin_s rx_signal_lost_chb,
  input wire logic partner_rx_lanes_aligned_chb,
  input wire logic tx_lanes_aligned_chb,
  output logic local_tx_lanes_aligned_chb,
  input wire logic channel_a_powerdown_n,
  input wire logic channel_b_powerdown_n,
  output logic cha_powered_down,
  output logic chb_powered_down,
  output logic chb_datapath_reset,
  input wire logic ref_clock_in_zero,
  input wire logic ref_clock_in_one,
  output logic cha_ref_clk,
  output logic chb_ref_clk,
  input wire logic [1:0] rec_byte_clk,
  input wire logic [1:0] vco_tick,
  output logic vco_sub_rate,
  output csc_pin_s channel_a_clock_out,
  output csc_pin_s channel_b_clock_out,
  input wire logic pattern_test_enable,
  output logic [CSC_NGEN-1:0] pattern_gen_en,
  output logic [CSC_NGEN-1:0] pattern_chk_en,
  input wire logic [CSC_NCHK-1:0] pattern_err,
  output csc_pin_s pattern_check_ok,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pin_sync;
  logic pd_a_pin;
  logic pd_b_pin;
  logic pat_en;
  logic partner_ok;

  csc_sync2 #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({partner_rx_lanes_aligned_chb, pattern_test_enable,
               ~channel_b_powerdown_n, ~channel_a_powerdown_n}),
    .sync_out(pin_sync)
  );

  assign pd_a_pin = pin_sync[0];
  assign pd_b_pin = pin_sync[1];
  assign pat_en = pin_sync[2];
  assign partner_ok = pin_sync[3];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  csc_ctrl_s ctrl;
  csc_ctrl_s next_ctrl;
  logic [CSC_SEL_W-1:0] chk_sel;
  logic [CSC_SEL_W-1:0] next_chk_sel;
  logic [CSC_INT_W-1:0] istat;
  logic [CSC_INT_W-1:0] next_istat;
  logic [CSC_INT_W-1:0] imask;
  logic [CSC_INT_W-1:0] next_imask;
  logic [CSC_DW-1:0] next_prdata;
  logic [CSC_INT_W-1:0] events;
  logic [CSC_ST_W-1:0] status;
  logic wr_en;
  logic setup;
  logic addr_ok;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign pready = 1'b1; // Every access finishes in its first access cycle

  always_comb
  begin
    case (paddr)
      CSC_REG_CTRL, CSC_REG_PSEL, CSC_REG_STAT, CSC_REG_ISTAT, CSC_REG_IMASK:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  always_comb
  begin
    next_ctrl = ctrl;
    next_ctrl.dp_reset_b = 1'b0; // Self-clearing strobe
    next_chk_sel = chk_sel;
    next_imask = imask;
    next_istat = istat;
    next_prdata = prdata;
    if (wr_en)
    begin
      case (paddr)
        CSC_REG_CTRL:
          next_ctrl = csc_ctrl_s'(pwdata[CSC_CTRL_W-1:0]);
        CSC_REG_PSEL:
          next_chk_sel = pwdata[CSC_SEL_W-1:0];
        CSC_REG_IMASK:
          next_imask = pwdata[CSC_INT_W-1:0];
        CSC_REG_ISTAT:
          next_istat = istat & ~pwdata[CSC_INT_W-1:0];
        default:
          next_istat = istat;
      endcase
    end
    // Set after clear so a coinciding event is kept
    next_istat = next_istat | events;
    if (setup)
    begin
      case (paddr)
        CSC_REG_CTRL:
          next_prdata = {{(CSC_DW-CSC_CTRL_W){1'b0}}, ctrl};
        CSC_REG_PSEL:
          next_prdata = {{(CSC_DW-CSC_SEL_W){1'b0}}, chk_sel};
        CSC_REG_STAT:
          next_prdata = {{(CSC_DW-CSC_ST_W){1'b0}}, status};
        CSC_REG_ISTAT:
          next_prdata = {{(CSC_DW-CSC_INT_W){1'b0}}, istat};
        CSC_REG_IMASK:
          next_prdata = {{(CSC_DW-CSC_INT_W){1'b0}}, imask};
        default:
          next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= csc_ctrl_s'(CSC_CTRL_RST);
      chk_sel <= CSC_PSEL_RST;
      istat <= '0;
      imask <= CSC_IMASK_RST;
      prdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      chk_sel <= next_chk_sel;
      istat <= next_istat;
      imask <= next_imask;
      prdata <= next_prdata;
    end
  end

  assign irq = |(istat & imask);

  ////////////////////////////////////////////////////////////////////////////
  // Power down, data path reset, reference clocks

  logic pd_a;
  logic pd_b;

  assign pd_a = pd_a_pin | ctrl.pd_reg_a;
  assign pd_b = pd_b_pin | ctrl.pd_reg_b;
  assign cha_powered_down = pd_a;
  assign chb_powered_down = pd_b;
  // Software strobe; controller is expected to issue it after power-up
  assign chb_datapath_reset = ctrl.dp_reset_b;

  // Glitch-free switching is the clock tree's job; this only steers
  assign cha_ref_clk = ctrl.ref_sel_a ? ref_clock_in_one : ref_clock_in_zero;
  assign chb_ref_clk = ctrl.ref_sel_b ? ref_clock_in_one : ref_clock_in_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Loss detect with hysteresis and observation pin

  logic los_q;
  logic next_los;
  logic los_d;
  logic partner_d;
  logic pd_b_d;
  csc_pin_s next_los_pin;

  always_comb
  begin
    next_los = los_q;
    if (!ctrl.los_en)
      next_los = 1'b0;
    else if (rx_swing_mvpp <= CSC_LOS_ASSERT_MVPP)
      next_los = 1'b1;
    else if (rx_swing_mvpp > CSC_LOS_DEASSERT_MVPP)
      next_los = 1'b0;
    next_los_pin.oe = ~pd_b;
    case (ctrl.obs_sel)
      CSC_OBS_LOS:
        next_los_pin.val = los_q;
      CSC_OBS_PARTNER:
        next_los_pin.val = partner_ok;
      CSC_OBS_TXALIGN:
        next_los_pin.val = local_tx_lanes_aligned_chb;
      CSC_OBS_PD:
        next_los_pin.val = pd_b;
      default:
        next_los_pin.val = los_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      los_q <= 1'b0;
      los_d <= 1'b0;
      partner_d <= 1'b0;
      pd_b_d <= 1'b0;
      rx_signal_lost_chb <= 2'b01;
    end
    else
    begin
      los_q <= next_los;
      los_d <= los_q;
      partner_d <= partner_ok;
      pd_b_d <= pd_b_pin;
      rx_signal_lost_chb <= next_los_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane alignment out

  logic next_txal;

  always_comb
  begin
    next_txal = ctrl.gp10g_mode & tx_lanes_aligned_chb & ~pd_b;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      local_tx_lanes_aligned_chb <= 1'b0;
    else
      local_tx_lanes_aligned_chb <= next_txal;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs

  logic both_pin_pd;
  logic [1:0] clk_en;
  csc_pin_s [1:0] clk_pins;

  assign both_pin_pd = pd_a_pin & pd_b_pin;
  assign clk_en[0] = ~both_pin_pd & ~ctrl.pd_reg_a;
  assign clk_en[1] = ~both_pin_pd & ~ctrl.pd_reg_b;
  // Oscillator runs 2x faster at sub-rates, giving rate/4 instead of rate/8
  assign vco_sub_rate = ctrl.sub_rate;

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_clk
      csc_clkout u_clkout (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rec_byte_clk(rec_byte_clk[c]),
        .vco_tick(vco_tick[c]),
        .vco_div(ctrl.clk_vco_div),
        .out_en(clk_en[c]),
        .clk_out(clk_pins[c])
      );
    end
  endgenerate

  assign channel_a_clock_out = clk_pins[0];
  assign channel_b_clock_out = clk_pins[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pattern test

  csc_pin_s next_pat_pin;

  assign pattern_gen_en = {CSC_NGEN{pat_en}};
  assign pattern_chk_en = {CSC_NGEN{pat_en}};

  always_comb
  begin
    next_pat_pin.oe = ~both_pin_pd & ~(ctrl.pd_reg_a & ctrl.pd_reg_b);
    next_pat_pin.val = 1'b1;
    if (pat_en && chk_sel < CSC_SEL_W'(CSC_NCHK))
      next_pat_pin.val = ~pattern_err[chk_sel];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pattern_check_ok <= 2'b11;
    else
      pattern_check_ok <= next_pat_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and status

  always_comb
  begin
    events = '0;
    events[CSC_INT_LOS] = los_q & ~los_d;
    events[CSC_INT_PARTNER] = ~partner_ok & partner_d;
    events[CSC_INT_PATERR] = pat_en & (|pattern_err);
    events[CSC_INT_PDREL] = ~pd_b_pin & pd_b_d;
    status = '0;
    status[CSC_ST_LOS] = los_q;
    status[CSC_ST_PARTNER] = partner_ok;
    status[CSC_ST_PDB] = pd_b;
    status[CSC_ST_PDA] = pd_a;
    status[CSC_ST_PATEN] = pat_en;
    status[CSC_ST_PATOK] = pattern_check_ok.val;
  end

endmodule

// *** csc_pkg.sv ***
// Constants, field layouts and carrier types for the channel status and control block.
// Assumes a 50 MHz sys_clk and an APB register port with 32-bit data.
//
// Behaviour
// - Loss output 0 with signal, 1 when lost
// - Assert at or below 75, release above 150
// - Loss pin can show other functions, register selected
// - Loss pin low in reset, floating when powered down
// - Drive transmit alignment output in 10G serializer mode
// - Power-down input low holds channel B down
// - Clock outputs default to recovered byte clock
// - Option: clock outputs carry oscillator divided by two
// - Divided clock is rate/8 full, rate/4 sub-rate
// - Clock outputs float in reset, with both power-down pins low, or per channel by register power down
// - Pattern-test input enables all generators and checkers
// - Pattern check high when clean, low on error
package csc_pkg;

  localparam int CSC_AW = 8;
  localparam int CSC_DW = 32;

  // Register byte addresses
  localparam logic [CSC_AW-1:0] CSC_REG_CTRL = 8'h00;
  localparam logic [CSC_AW-1:0] CSC_REG_PSEL = 8'h04;
  localparam logic [CSC_AW-1:0] CSC_REG_STAT = 8'h08;
  localparam logic [CSC_AW-1:0] CSC_REG_ISTAT = 8'h0C;
  localparam logic [CSC_AW-1:0] CSC_REG_IMASK = 8'h10;

  typedef enum logic [1:0] {
    CSC_OBS_LOS = 2'b00,
    CSC_OBS_PARTNER = 2'b01,
    CSC_OBS_TXALIGN = 2'b10,
    CSC_OBS_PD = 2'b11
  } csc_obs_e;

  // Control register, bit 0 is los_en
  typedef struct packed {
    logic sub_rate;
    logic clk_vco_div;
    logic ref_sel_b;
    logic ref_sel_a;
    csc_obs_e obs_sel;
    logic dp_reset_b;
    logic pd_reg_a;
    logic pd_reg_b;
    logic gp10g_mode;
    logic los_en;
  } csc_ctrl_s;

  localparam int CSC_CTRL_W = 11;
  localparam logic [CSC_CTRL_W-1:0] CSC_CTRL_RST = 11'h001;

  // Output pin with its enable
  typedef struct packed {
    logic val;
    logic oe;
  } csc_pin_s;

  // Checker index: 0 A hs, 1-4 A ls lanes, 5 B hs, 6-9 B ls lanes
  localparam int CSC_NCHK = 10;
  localparam int CSC_SEL_W = 4;
  localparam logic [CSC_SEL_W-1:0] CSC_PSEL_RST = 4'h5;
  localparam int CSC_NGEN = 4;

  localparam logic [7:0] CSC_LOS_ASSERT_MVPP = 8'h4B;
  localparam logic [7:0] CSC_LOS_DEASSERT_MVPP = 8'h96;

  // Interrupt bit positions
  localparam int CSC_INT_W = 4;
  localparam int CSC_INT_LOS = 0;
  localparam int CSC_INT_PARTNER = 1;
  localparam int CSC_INT_PATERR = 2;
  localparam int CSC_INT_PDREL = 3;
  localparam logic [CSC_INT_W-1:0] CSC_IMASK_RST = 4'h0;

  // Status register bit positions
  localparam int CSC_ST_LOS = 0;
  localparam int CSC_ST_PARTNER = 1;
  localparam int CSC_ST_PDB = 2;
  localparam int CSC_ST_PDA = 3;
  localparam int CSC_ST_PATEN = 4;
  localparam int CSC_ST_PATOK = 5;
  localparam int CSC_ST_W = 6;

endpackage

// *** csc_sync2.sv ***
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous levels; the first stage feeds only the second.
`timescale 1ns/10ps
module csc_sync2
  import csc_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// *** csc_clkout.sv ***
// One channel clock output: recovered byte clock or oscillator divided by two.
// Assumes rec_byte_clk and vco_tick are produced in the sys_clk domain.
`timescale 1ns/10ps
module csc_clkout
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rec_byte_clk,
  input wire logic vco_tick,
  input wire logic vco_div,
  input wire logic out_en,
  output csc_pin_s clk_out
);

  logic div_q;
  logic next_div;
  csc_pin_s next_out;

  always_comb
  begin
    next_div = vco_tick ? ~div_q : div_q;
    next_out.val = vco_div ? div_q : rec_byte_clk;
    next_out.oe = out_en;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 1'b0;
      clk_out <= '0;
    end
    else
    begin
      div_q <= next_div;
      clk_out <= next_out;
    end
  end

endmodule

// *** csc_link_partner.sv ***
// Link partner lane alignment slave model for channel B.
// Assumes the shared sys_clk; slow adds one cycle of lag to the answer.
`timescale 1ns/10ps
module csc_link_partner
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lanes_ok,
  input wire logic slow,
  output logic partner_rx_lanes_aligned_chb
);
  logic lag;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      lag <= 1'b0;
      partner_rx_lanes_aligned_chb <= 1'b0;
    end
    else
    begin
      lag <= lanes_ok;
      partner_rx_lanes_aligned_chb <= slow ? lag : lanes_ok;
    end
endmodule

// *** csc_channel_status_monitor.sv ***
// Port checks for the channel status block.
// Assumes one sys_clk domain; CTRL is shadowed from APB writes.
`timescale 1ns/10ps
module csc_channel_status_monitor
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [CSC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSC_DW-1:0] pwdata,
  input wire logic [7:0] rx_swing_mvpp,
  input wire csc_pin_s rx_signal_lost_chb,
  input wire logic tx_lanes_aligned_chb,
  input wire logic local_tx_lanes_aligned_chb,
  input wire logic channel_a_powerdown_n,
  input wire logic channel_b_powerdown_n,
  input wire logic chb_powered_down,
  input wire logic pattern_test_enable,
  input wire logic [CSC_NGEN-1:0] pattern_gen_en,
  input wire logic [CSC_NGEN-1:0] pattern_chk_en,
  input wire csc_pin_s channel_a_clock_out,
  input wire csc_pin_s channel_b_clock_out
);
  csc_ctrl_s ctrl;
  csc_ctrl_s next_ctrl;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_comb
  begin
    next_ctrl = ctrl;
    if (psel && penable && pwrite && paddr == CSC_REG_CTRL)
      next_ctrl = csc_ctrl_s'(pwdata[CSC_CTRL_W-1:0]);
  end
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      ctrl <= csc_ctrl_s'(CSC_CTRL_RST);
    else
      ctrl <= next_ctrl;
  ////////////////////////////////////////
  property p_los_set;
    (ctrl.los_en && ctrl.obs_sel == CSC_OBS_LOS && rx_swing_mvpp <= CSC_LOS_ASSERT_MVPP)[*3]
      |-> rx_signal_lost_chb.val;
  endproperty
  a_los_set: assert property (p_los_set) else $error("loss not shown");
  property p_los_clr;
    (ctrl.obs_sel == CSC_OBS_LOS && (rx_swing_mvpp > CSC_LOS_DEASSERT_MVPP || !ctrl.los_en))[*3]
      |-> !rx_signal_lost_chb.val;
  endproperty
  a_los_clr: assert property (p_los_clr) else $error("loss shown with signal");
  property p_los_rst;
    disable iff (1'b0) !rst_n |-> !rx_signal_lost_chb.val && rx_signal_lost_chb.oe;
  endproperty
  a_los_rst: assert property (p_los_rst) else $error("loss pin not low in reset");
  property p_los_float;
    (!channel_b_powerdown_n)[*4] |-> !rx_signal_lost_chb.oe;
  endproperty
  a_los_float: assert property (p_los_float) else $error("loss pin driven");
  property p_txal;
    local_tx_lanes_aligned_chb ==
      $past(ctrl.gp10g_mode && tx_lanes_aligned_chb && !chb_powered_down);
  endproperty
  a_txal: assert property (p_txal) else $error("tx alignment output wrong");
  property p_pd_in;
    (!channel_b_powerdown_n)[*3] |-> chb_powered_down;
  endproperty
  a_pd_in: assert property (p_pd_in) else $error("channel B not powered down");
  property p_pd_sync;
    (channel_b_powerdown_n && !ctrl.pd_reg_b)[*3] ##1 (!channel_b_powerdown_n && !ctrl.pd_reg_b)
      |-> !chb_powered_down;
  endproperty
  a_pd_sync: assert property (p_pd_sync) else $error("power-down not synchronised");
  property p_pat_en;
    pattern_test_enable[*3] |-> (&pattern_gen_en) && (&pattern_chk_en);
  endproperty
  a_pat_en: assert property (p_pat_en) else $error("pattern engines off");
  // Checked in reset as well, so the reset disable is switched off here
  property p_clk_float;
    disable iff (1'b0)
    (!rst_n or (!channel_a_powerdown_n && !channel_b_powerdown_n)[*4])
      |-> !channel_a_clock_out.oe && !channel_b_clock_out.oe;
  endproperty
  a_clk_float: assert property (p_clk_float) else $error("clock driven");
  c_loss: cover property (rx_signal_lost_chb.val && rx_signal_lost_chb.oe);
  c_align: cover property (local_tx_lanes_aligned_chb);
  c_pd: cover property (chb_powered_down ##4 !chb_powered_down);
endmodule

bind csc_channel_status csc_channel_status_monitor csc_channel_status_monitor_i (.*);

// *** tb_csc_channel_status.sv ***
// Self-checking bench for the channel status block and its link partner.
// Assumes the monitor binds itself; one 50 MHz clock.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_csc_channel_status
  import csc_pkg::*;
;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [CSC_AW-1:0] paddr;
  logic [CSC_DW-1:0] pwdata, prdata, rd, r;
  logic [7:0] rx_swing_mvpp;
  csc_pin_s rx_signal_lost_chb, channel_a_clock_out, channel_b_clock_out, pattern_check_ok;
  logic partner_rx_lanes_aligned_chb, tx_lanes_aligned_chb, local_tx_lanes_aligned_chb;
  logic channel_a_powerdown_n, channel_b_powerdown_n, cha_powered_down, chb_powered_down;
  logic chb_datapath_reset, ref_clock_in_zero, ref_clock_in_one, cha_ref_clk, chb_ref_clk;
  logic [1:0] rec_byte_clk, vco_tick;
  logic vco_sub_rate, pattern_test_enable, lanes_ok, slow;
  logic [CSC_NGEN-1:0] pattern_gen_en, pattern_chk_en;
  logic [CSC_NCHK-1:0] pattern_err;
  int mismatches, checked, n, s, t;
  csc_channel_status csc_channel_status_i (.*);
  csc_link_partner csc_link_partner_i (.*);
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  function automatic logic pat_exp(input int sel, input logic [CSC_NCHK-1:0] e);
    return (sel >= CSC_NCHK) ? 1'b1 : !e[sel];
  endfunction
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Starts on a fresh edge so psel never gets two values in one step
  task automatic apb(input logic w, input logic [CSC_AW-1:0] a, input logic [CSC_DW-1:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    test_done();
  end
  ////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, tx_lanes_aligned_chb, rec_byte_clk} = '0;
    {ref_clock_in_zero, vco_tick, pattern_test_enable, pattern_err, lanes_ok, slow} = '0;
    {rst_n, channel_a_powerdown_n, channel_b_powerdown_n, ref_clock_in_one} = '1;
    rx_swing_mvpp = 8'hC8;
    {mismatches, checked, t} = '0;
    void'($urandom(32'h7993));
    // Clean falling edge after time zero, so every flop sees the reset
    #1 rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, CSC_REG_CTRL, 32'h0);
    `CHK(rd[CSC_CTRL_W-1:0], CSC_CTRL_RST);
    apb(1'b0, CSC_REG_PSEL, 32'h0);
    `CHK(rd[CSC_SEL_W-1:0], CSC_PSEL_RST);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({serr, rd}, {1'b1, 32'h0});
    apb(1'b1, CSC_REG_ISTAT, 32'hF);
    apb(1'b1, CSC_REG_IMASK, 32'h1);
    for (n = 0; n < 16; n++)
    begin
      @(posedge sys_clk);
      s = n[0] ? $urandom_range(0, 75) : $urandom_range(151, 255);
      if (n < 2)
        s = n[0] ? 75 : 151;
      rx_swing_mvpp <= 8'(s);
      wt(3);
      `CHK(rx_signal_lost_chb.val, s <= 75);
    end
    `CHK(irq, 1'b1);
    for (n = 0; n < 3; n++)
    begin
      apb(1'b1, n == 2 ? CSC_REG_ISTAT : CSC_REG_IMASK, 32'(n != 0));
      wt(1);
      `CHK(irq, n == 1);
    end
    for (n = 0; n < 8; n++)
    begin
      @(posedge sys_clk);
      s = $urandom;
      lanes_ok <= s[0];
      slow <= s[1];
      tx_lanes_aligned_chb <= s[2];
      apb(1'b1, CSC_REG_CTRL, 32'(s[3] ? 8'h43 : 8'h23));
      wt(5);
      `CHK(local_tx_lanes_aligned_chb, s[2]);
      `CHK(rx_signal_lost_chb.val, s[3] ? s[2] : s[0]);
    end
    apb(1'b1, CSC_REG_CTRL, 32'h1);
    wt(2);
    `CHK(local_tx_lanes_aligned_chb, 1'b0);
    for (n = 0; n < 2; n++)
    begin
      @(posedge sys_clk);
      channel_b_powerdown_n <= n[0];
      wt(4);
      `CHK({chb_powered_down, rx_signal_lost_chb.oe}, {!n[0], n[0]});
    end
    apb(1'b0, CSC_REG_ISTAT, 32'h0);
    `CHK(rd[CSC_INT_PDREL], 1'b1);
    apb(1'b1, CSC_REG_CTRL, 32'h11);
    @(negedge sys_clk);
    `CHK(chb_datapath_reset, 1'b1);
    apb(1'b1, CSC_REG_CTRL, 32'h65);
    wt(2);
    `CHK(rx_signal_lost_chb, 2'b10);
    `CHK({channel_a_clock_out.oe, channel_b_clock_out.oe}, 2'b10);
    for (n = 0; n < 2; n++)
    begin
      @(posedge sys_clk);
      {channel_a_powerdown_n, channel_b_powerdown_n} <= {2{n[0]}};
      wt(4);
      `CHK({channel_a_clock_out.oe, channel_b_clock_out.oe}, {n[0], 1'b0});
      `CHK({cha_powered_down, pattern_check_ok.oe}, {!n[0], n[0]});
    end
    apb(1'b1, CSC_REG_CTRL, 32'h1);
    for (n = 0; n < 8; n++)
    begin
      @(posedge sys_clk);
      s = $urandom;
      rec_byte_clk <= s[1:0];
      wt(1);
      `CHK({channel_a_clock_out, channel_b_clock_out}, {s[0], 1'b1, s[1], 1'b1});
    end
    apb(1'b1, CSC_REG_CTRL, 32'h201);
    wt(2);
    `CHK({channel_a_clock_out.val, channel_b_clock_out.val}, 2'b00);
    for (n = 0; n < 16; n++)
    begin
      @(posedge sys_clk);
      r = $urandom;
      vco_tick <= r[1:0];
      t ^= r[1:0];
    end
    @(posedge sys_clk);
    vco_tick <= 2'b00;
    wt(3);
    `CHK({channel_a_clock_out.val, channel_b_clock_out.val}, {t[0], t[1]});
    apb(1'b1, CSC_REG_CTRL, 32'h601);
    wt(1);
    `CHK(vco_sub_rate, 1'b1);
    for (n = 0; n < 4; n++)
    begin
      apb(1'b1, CSC_REG_CTRL, 32'(1 | (n << 7)));
      s = $urandom;
      {ref_clock_in_one, ref_clock_in_zero} <= s[1:0];
      @(negedge sys_clk);
      `CHK({cha_ref_clk, chb_ref_clk}, {s[n[0]], s[n[1]]});
    end
    @(posedge sys_clk);
    pattern_test_enable <= 1'b1;
    wt(3);
    `CHK({pattern_gen_en, pattern_chk_en}, 8'hFF);
    for (n = 0; n < 12; n++)
    begin
      s = (n == 11) ? 12 : $urandom_range(0, 9);
      apb(1'b1, CSC_REG_PSEL, 32'(s));
      r = $urandom;
      pattern_err <= r[CSC_NCHK-1:0];
      wt(2);
      `CHK(pattern_check_ok.val, pat_exp(s, r[CSC_NCHK-1:0]));
    end
    @(posedge sys_clk);
    pattern_test_enable <= 1'b0;
    pattern_err <= '1;
    wt(3);
    `CHK({pattern_check_ok.val, pattern_gen_en}, 5'h10);
    test_done();
  end
endmodule
